// [hw/udgc_ctrl.sv]
// Purpose: general control of a full-speed usb device controller
// Assumes: one clock aclk 25 MHz, sync active-low aresetn, axi4-lite
// Notes: frozen clock modelled as an enable; wake-up caught from synchronised lines
//
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module udgc_ctrl #(
    parameter int NUM_EP = udgc_pkg::NUM_EP
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    sys_reset_req,
    input  wire logic                    bus_reset_end,
    input  wire logic                    bus_suspend_det,
    input  wire logic [NUM_EP*8-1:0]     ep_events,
    input  wire logic                    dp_in,
    input  wire logic                    dm_in,
    output logic                         dp_out,
    output logic                         dm_out,
    output logic                         dp_oe,
    output logic                         dm_oe,
    output logic                         pad_idle,
    output logic                         ctrl_reset,
    output logic                         usb_clk_en,
    output logic                         irq_general,
    output logic                         irq_endpoint,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);
    import udgc_pkg::*;

    logic [7:0]                gen_ctrl_r;
    logic [7:0]                dev_ctrl_r;
    logic [7:0]                dev_int_r;
    logic [7:0]                dev_int_en_r;
    logic [15:0]               dp_addr_r;
    udgc_line_type             line_r;
    logic [2:0]                ep_sel_r;
    udgc_ep_cfg_type           ep_cfg_r  [NUM_EP];
    logic [7:0]                ep_int_r  [NUM_EP];
    logic [7:0]                ep_ien_r  [NUM_EP];
    logic [7:0]                ep_base_r [NUM_EP];
    logic [1:0]                dp_sync_r;
    logic [1:0]                dm_sync_r;
    logic [1:0]                line_q_r;
    logic [1:0]                susp_sync_r;
    logic [1:0]                rst_end_sync_r;
    logic                      rst_end_q_r;
    logic                      aw_hold_r;
    logic                      w_hold_r;
    logic [7:0]                aw_addr_r;
    logic [31:0]               w_data_r;
    logic [3:0]                w_strb_r;
    logic                      macro_en;
    logic                      frozen;
    logic                      clk_run;
    logic                      rst_end_pulse;
    logic                      line_change;
    logic                      wr_fire;
    logic                      wr_lane0;
    logic [7:0]                wr_ofs;
    logic [7:0]                wr_byte;
    logic [NUM_EP-1:0]         ep_hit;
    logic [31:0]               rd_val;
    logic                      rd_ok;
    logic [7:0]                ep_size [NUM_EP];

    assign macro_en    = gen_ctrl_r[BIT_MACRO_EN];
    assign frozen      = gen_ctrl_r[BIT_FREEZE];
    assign clk_run     = macro_en && !frozen;
    assign usb_clk_en  = clk_run;
    assign ctrl_reset  = !macro_en || rst_end_pulse;
    assign line_change = line_q_r != {dp_sync_r[1], dm_sync_r[1]};
    assign rst_end_pulse = rst_end_sync_r[1] && !rst_end_q_r;

    // axi write channel capture in either order
    assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
    assign wr_fire       = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign wr_ofs        = aw_addr_r;
    assign wr_byte       = w_data_r[7:0];
    assign wr_lane0      = wr_fire && w_strb_r[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
            end else if (wr_fire) begin
                aw_hold_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_ofs > OFS_EVENTS) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // line and bus input synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dp_sync_r   <= 2'b00;
            dm_sync_r   <= 2'b00;
            susp_sync_r <= 2'b00;
            rst_end_sync_r <= 2'b00;
            rst_end_q_r    <= 1'b0;
            line_q_r    <= 2'b00;
        end else begin
            dp_sync_r   <= {dp_sync_r[0], dp_in};
            dm_sync_r   <= {dm_sync_r[0], dm_in};
            susp_sync_r <= {susp_sync_r[0], bus_suspend_det};
            rst_end_sync_r <= {rst_end_sync_r[0], bus_reset_end};
            rst_end_q_r    <= rst_end_sync_r[1];
            line_q_r    <= {dp_sync_r[1], dm_sync_r[1]};
        end
    end

    // general control: enable and freeze; system reset disables
    always_ff @(posedge aclk) begin
        if (!aresetn || sys_reset_req) begin
            gen_ctrl_r <= GEN_CTRL_RST;
        end else if (wr_lane0 && wr_ofs == OFS_GEN_CTRL) begin
            gen_ctrl_r <= wr_byte & GEN_CTRL_MASK;
        end
    end

    // device control holds the disconnect bit; writable while frozen
    always_ff @(posedge aclk) begin
        if (!aresetn || sys_reset_req || !macro_en) begin
            dev_ctrl_r <= DEV_CTRL_RST;
        end else if (wr_lane0 && wr_ofs == OFS_DEV_CTRL) begin
            dev_ctrl_r <= wr_byte;
        end
    end

    // direct-access address, enable, speed survive controller reset
    always_ff @(posedge aclk) begin
        if (!aresetn || sys_reset_req) begin
            dp_addr_r <= 16'h0000;
        end else if (wr_fire && wr_ofs == OFS_DP_ADDR) begin
            if (w_strb_r[0]) dp_addr_r[7:0]  <= w_data_r[7:0];
            if (w_strb_r[1]) dp_addr_r[15:8] <= w_data_r[15:8];
        end
    end

    // device interrupt flags: set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn || sys_reset_req || !macro_en) begin
            dev_int_r <= 8'h00;
        end else begin
            if (wr_lane0 && wr_ofs == OFS_DEV_INT) begin
                dev_int_r <= dev_int_r & wr_byte;
            end
            if (line_change) begin
                dev_int_r[BIT_WAKE] <= 1'b1;
            end
            if (clk_run && susp_sync_r[1]) begin
                dev_int_r[BIT_SUSP] <= 1'b1;
            end
            if (clk_run && rst_end_pulse) begin
                dev_int_r[BIT_RST_END] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || sys_reset_req || !macro_en) begin
            dev_int_en_r <= 8'h00;
        end else if (wr_lane0 && wr_ofs == OFS_DEV_INT_EN) begin
            dev_int_en_r <= wr_byte;
        end
    end

    // pad idles on suspend or detach, wakes on any line change unless detached
    always_ff @(posedge aclk) begin
        if (!aresetn || sys_reset_req || !macro_en) begin
            pad_idle <= 1'b1;
        end else if (dev_ctrl_r[BIT_DETACH]) begin
            pad_idle <= 1'b1;
        end else if (line_change) begin
            pad_idle <= 1'b0;
        end else if (dev_int_r[BIT_SUSP] && clk_run && susp_sync_r[1]) begin
            pad_idle <= 1'b1;
        end else if (!dev_int_r[BIT_SUSP]) begin
            pad_idle <= 1'b0;
        end
    end

    // direct line drive only accepted while enabled
    always_ff @(posedge aclk) begin
        if (!aresetn || sys_reset_req || !macro_en) begin
            line_r <= '0;
        end else if (wr_lane0 && wr_ofs == OFS_LINE) begin
            line_r <= wr_byte[7:4];
        end
    end
    assign dp_oe  = macro_en && line_r.drive_mode == DRIVE_DIRECT;
    assign dm_oe  = dp_oe;
    assign dp_out = line_r.dp_val;
    assign dm_out = line_r.dm_val;

    always_ff @(posedge aclk) begin
        if (!aresetn || ctrl_reset) begin
            ep_sel_r <= 3'h0;
        end else if (clk_run && wr_lane0 && wr_ofs == OFS_EP_SEL) begin
            ep_sel_r <= wr_byte[2:0];
        end
    end

    // per-endpoint config, flags, enables and memory base
    generate
        for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
            logic sel_wr;
            assign ep_hit[e]  = ep_sel_r == 3'(e);
            assign sel_wr     = clk_run && wr_lane0 && ep_hit[e];
            assign ep_size[e] = 8'(SIZE_UNIT) << ep_cfg_r[e].size_code;

            always_ff @(posedge aclk) begin
                if (!aresetn || ctrl_reset) begin
                    ep_cfg_r[e] <= '0;
                end else if (sel_wr && wr_ofs == OFS_EP_CFG) begin
                    ep_cfg_r[e].activate  <= wr_byte[0];
                    ep_cfg_r[e].reserve   <= wr_byte[1];
                    ep_cfg_r[e].size_code <= wr_byte[6:4];
                    ep_cfg_r[e].bank_two  <= wr_byte[2];
                    ep_cfg_r[e].cfg_ok    <= wr_byte[1];
                end
            end

            // base follows previous endpoint; only the next one slides
            if (e == 0) begin : g_base0
                assign ep_base_r[e] = 8'h00;
            end else begin : g_basen
                logic below_wr_r;
                // moves only right after the endpoint below is reconfigured
                always_ff @(posedge aclk) begin
                    if (!aresetn || ctrl_reset) begin
                        ep_base_r[e] <= 8'h00;
                        below_wr_r   <= 1'b0;
                    end else begin
                        below_wr_r <= clk_run && wr_lane0 && ep_hit[e-1] && wr_ofs == OFS_EP_CFG;
                        if (below_wr_r && ep_cfg_r[e-1].reserve) begin
                            ep_base_r[e] <= 8'(ep_base_r[e-1] + (ep_size[e-1] << ep_cfg_r[e-1].bank_two));
                        end else if (below_wr_r) begin
                            ep_base_r[e] <= ep_base_r[e-1];
                        end
                    end
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn || ctrl_reset) begin
                    ep_ien_r[e] <= 8'h00;
                end else if (sel_wr && wr_ofs == OFS_EP_INT_EN) begin
                    ep_ien_r[e] <= wr_byte;
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn || ctrl_reset) begin
                    ep_int_r[e] <= 8'h00;
                end else begin
                    if (sel_wr && wr_ofs == OFS_EP_INT) begin
                        ep_int_r[e] <= ep_int_r[e] & wr_byte;
                    end
                    for (int s = 0; s < EP_SRC; s++) begin
                        if (clk_run && ep_events[e*EP_SRC+s]) begin
                            ep_int_r[e][s] <= 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    // endpoint and general requests
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_endpoint <= 1'b0;
            irq_general  <= 1'b0;
        end else begin
            irq_endpoint <= 1'b0;
            for (int e = 0; e < NUM_EP; e++) begin
                if (|(ep_int_r[e] & ep_ien_r[e]) && !frozen) begin
                    irq_endpoint <= 1'b1;
                end
            end
            irq_general <= frozen ? (dev_int_r[BIT_WAKE] && dev_int_en_r[BIT_WAKE])
                                  : |(dev_int_r & dev_int_en_r);
        end
    end

    // read mux; frozen registers stay readable
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b1;
        unique case (s_axi_araddr[7:2])
            OFS_GEN_CTRL[7:2]:   rd_val[7:0]  = gen_ctrl_r;
            OFS_DEV_CTRL[7:2]:   rd_val[7:0]  = dev_ctrl_r;
            OFS_DEV_INT[7:2]:    rd_val[7:0]  = dev_int_r;
            OFS_DEV_INT_EN[7:2]: rd_val[7:0]  = dev_int_en_r;
            OFS_DP_ADDR[7:2]:    rd_val[15:0] = dp_addr_r;
            OFS_LINE[7:2]:       rd_val[7:0]  = {line_r, 2'b00, dp_sync_r[1], dm_sync_r[1]};
            OFS_EP_SEL[7:2]:     rd_val[2:0]  = ep_sel_r;
            OFS_EP_CFG[7:2]:     rd_val[7:0]  = {1'b0, ep_cfg_r[ep_sel_r].size_code, ep_cfg_r[ep_sel_r].cfg_ok,
                                                 ep_cfg_r[ep_sel_r].bank_two, ep_cfg_r[ep_sel_r].reserve,
                                                 ep_cfg_r[ep_sel_r].activate};
            OFS_EP_INT[7:2]:     rd_val[7:0]  = ep_int_r[ep_sel_r];
            OFS_EP_INT_EN[7:2]:  rd_val[7:0]  = ep_ien_r[ep_sel_r];
            OFS_EP_BASE[7:2]:    rd_val[7:0]  = ep_base_r[ep_sel_r];
            OFS_EVENTS[7:2]: begin
                for (int e = 0; e < NUM_EP; e++) begin
                    rd_val[e] = |(ep_int_r[e] & ep_ien_r[e]);
                end
            end
            default:             rd_ok        = 1'b0;
        endcase
        if (ep_sel_r >= 3'(NUM_EP) && s_axi_araddr[7:2] >= OFS_EP_CFG[7:2]
            && s_axi_araddr[7:2] <= OFS_EP_BASE[7:2]) begin
            rd_val = 32'h0000_0000;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    a_enable_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        sys_reset_req |=> !gen_ctrl_r[BIT_MACRO_EN] && gen_ctrl_r[BIT_FREEZE])
        else $error("system reset did not disable controller");
    a_rst_end_en: assert property (@(posedge aclk) disable iff (!aresetn)
        (rst_end_pulse && macro_en && !sys_reset_req && !wr_fire) |=> macro_en)
        else $error("bus reset dropped enable");
    a_frozen_ep_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(frozen) |-> !irq_endpoint)
        else $error("endpoint request while frozen");
    a_drive_needs_en: assert property (@(posedge aclk) disable iff (!aresetn)
        dp_oe |-> macro_en)
        else $error("line driven while disabled");
    a_detach_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        dev_ctrl_r[BIT_DETACH] |=> pad_idle)
        else $error("pad active while detached");
    a_wake_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        (line_change && macro_en && !sys_reset_req) |=> dev_int_r[BIT_WAKE])
        else $error("wake flag missed");
    a_ep_request: assert property (@(posedge aclk) disable iff (!aresetn)
        (|(ep_int_r[0] & ep_ien_r[0]) && !frozen) |=> irq_endpoint)
        else $error("endpoint request missing");
    a_dp_addr_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        (!macro_en && !sys_reset_req && !(wr_fire && wr_ofs == OFS_DP_ADDR)) |=> $stable(dp_addr_r))
        else $error("direct address lost in reset");
    c_enable: cover property (@(posedge aclk) disable iff (!aresetn) $rose(macro_en));
    c_freeze_wake: cover property (@(posedge aclk) disable iff (!aresetn) frozen && irq_general);
    c_ep_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq_endpoint));
endmodule : udgc_ctrl

// [shared/udgc_pkg.sv]
// Purpose: constants and types for the usb general control block
// Assumes: axi4-lite slave, 32-bit data, byte offsets below
// Notes: all register offsets are local choices
// Operation
// - system resets disable, reset controller; bus reset only resets it
// - bus end-of-reset resets state, stays enabled
// - reset state: enable clear, freeze set, suspended
// - direct access, address, speed writable in reset
// - macro enable bit 7 controls controller, buffers
// - separate general and endpoint interrupt requests
// - wake-up detected on line change without clock
// - other interrupt sources need running clock
// - eight enabled flag sources per endpoint
// - endpoint request; device register names endpoint
// - key registers stay accessible while frozen
// - only wake-up interrupt raised while frozen
// - freeze bit 5 gates clock, keeps flags
// - reserve inserts memory, shifts next endpoint up
// - disable keeps reservation; unreserve shifts next down
// - endpoint 0 data kept unless itself deactivated
// - same-parameter reactivation does not shift higher
// - config valid set even on overlap
// - suspend idles pad; non-idle event wakes it
// - disconnect bit idles pad; clearing reactivates
// - line drive needs enable; line read always
package udgc_pkg;
    localparam int          NUM_EP          = 5;
    localparam int          EP_SRC          = 8;
    localparam logic [7:0]  OFS_GEN_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_DEV_CTRL    = 8'h04;
    localparam logic [7:0]  OFS_DEV_INT     = 8'h08;
    localparam logic [7:0]  OFS_DEV_INT_EN  = 8'h0c;
    localparam logic [7:0]  OFS_DP_ADDR     = 8'h10;
    localparam logic [7:0]  OFS_LINE        = 8'h14;
    localparam logic [7:0]  OFS_EP_SEL      = 8'h18;
    localparam logic [7:0]  OFS_EP_CFG      = 8'h1c;
    localparam logic [7:0]  OFS_EP_INT      = 8'h20;
    localparam logic [7:0]  OFS_EP_INT_EN   = 8'h24;
    localparam logic [7:0]  OFS_EP_BASE     = 8'h28;
    localparam logic [7:0]  OFS_EVENTS      = 8'h2c;
    localparam int          BIT_MACRO_EN    = 7;
    localparam int          BIT_FREEZE      = 5;
    localparam logic [7:0]  GEN_CTRL_RST    = 8'h20;
    localparam logic [7:0]  GEN_CTRL_MASK   = 8'ha0;
    localparam int          BIT_DETACH      = 0;
    localparam int          BIT_SUSP        = 0;
    localparam int          BIT_WAKE        = 4;
    localparam int          BIT_RST_END     = 3;
    localparam logic [7:0]  DEV_CTRL_RST    = 8'h01;
    localparam int          DP_ADDR_W       = 11;
    localparam int          BIT_DP_ACC      = 15;
    localparam int          SPD_LSB         = 12;
    localparam logic [1:0]  DRIVE_DIRECT    = 2'b10;
    localparam int          ADDR_W          = 8;
    localparam int          SIZE_UNIT       = 8;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
    typedef struct packed {
        logic       activate;
        logic       reserve;
        logic [2:0] size_code;
        logic       bank_two;
        logic       cfg_ok;
    } udgc_ep_cfg_type;
    typedef struct packed {
        logic [1:0] drive_mode;
        logic       dp_val;
        logic       dm_val;
    } udgc_line_type;
endpackage : udgc_pkg

// [verif/udgc_host.sv]
// Purpose: host end of the full-speed lines for the bench
// Assumes: idle is J, dp high and dm low
// Notes: device drive wins while its enable is high
`timescale 1ns/1ps
module udgc_host (
    input  wire logic aclk,
    input  wire logic dp_oe,
    input  wire logic dp_out,
    input  wire logic dm_oe,
    input  wire logic dm_out,
    output logic      dp_in,
    output logic      dm_in,
    output logic      bus_reset_end,
    output logic      bus_suspend_det
);
    logic dp_h = 1'b1;
    logic dm_h = 1'b0;
    assign dp_in = dp_oe ? dp_out : dp_h;
    assign dm_in = dm_oe ? dm_out : dm_h;
    initial bus_reset_end = 1'b0;
    initial bus_suspend_det = 1'b0;
    // line state, suspend and end-of-reset held n cycles
    task automatic drive(input logic dp, input logic dm, input logic sus, input logic rst_end, input int n);
        @(posedge aclk);
        dp_h <= dp;
        dm_h <= dm;
        bus_suspend_det <= sus;
        bus_reset_end <= rst_end;
        repeat (n) @(posedge aclk);
    endtask : drive
endmodule : udgc_host

// [verif/usb_device_general_control_bench.sv]
// Purpose: self-checking bench for udgc_ctrl
// Assumes: axi4-lite master here, host model on the lines
// Notes: reads queue their expected word, a monitor compares
`timescale 1ns/1ps
module usb_device_general_control_bench;
    import udgc_pkg::*;
    logic                aclk, aresetn, sys_reset_req, awvalid, wvalid, bready, arvalid, rready;
    logic [NUM_EP*8-1:0] ep_events;
    logic [7:0]          awaddr, araddr;
    logic [31:0]         wdata, rdata;
    logic [1:0]          bresp, rresp;
    logic                awready, wready, bvalid, arready, rvalid, dp_in, dm_in, dp_out, dm_out;
    logic                dp_oe, dm_oe, pad_idle, ctrl_reset, usb_clk_en, irq_general, irq_endpoint;
    logic                bus_reset_end, bus_suspend_det;
    logic [33:0]         exp_q[$];
    logic [1:0]          resp_q[$];
    int                  err_count = 0;
    int                  checks = 0;
    int                  s;
    udgc_ctrl dut_u (.aclk, .aresetn, .sys_reset_req, .bus_reset_end, .bus_suspend_det, .ep_events,
        .dp_in, .dm_in, .dp_out, .dm_out, .dp_oe, .dm_oe, .pad_idle, .ctrl_reset, .usb_clk_en,
        .irq_general, .irq_endpoint, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    udgc_host host_u (.aclk, .dp_oe, .dp_out, .dm_oe, .dm_out, .dp_in, .dm_in, .bus_reset_end,
        .bus_suspend_det);
    task automatic cmp(input logic [33:0] g, input logic [33:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : cmp
    task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: write response %h want %h", $time, g, e);
        end
    endtask : cmp_resp
    task automatic finish_test();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        resp_q.push_back((a > OFS_EVENTS) ? RESP_SLVERR : RESP_OKAY);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        fork
            begin
                @(posedge aclk iff awready);
                awvalid <= 1'b0;
            end
            begin
                @(posedge aclk iff wready);
                wvalid <= 1'b0;
            end
        join
        @(posedge aclk iff bvalid);
        bready <= 1'b0;
        @(negedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        exp_q.push_back(e);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        @(posedge aclk iff arready);
        arvalid <= 1'b0;
        @(posedge aclk iff rvalid);
        rready <= 1'b0;
    endtask : rd
    task automatic pulse();
        @(posedge aclk);
        ep_events[s] <= 1'b1;
        @(posedge aclk);
        ep_events[s] <= 1'b0;
        repeat (4) @(negedge aclk);
    endtask : pulse
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            cmp({rresp, rdata}, exp_q.pop_front());
        end
        if (bvalid === 1'b1 && bready === 1'b1) begin
            cmp_resp(bresp, resp_q.pop_front());
        end
    end
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial begin
        #400000;
        err_count++;
        finish_test();
    end
    initial begin
        {aresetn, sys_reset_req, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, ep_events} = '0;
        void'($urandom(15));
        s = $urandom_range(7, 0);
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_GEN_CTRL, {RESP_OKAY, 32'h20});
        rd(OFS_DEV_CTRL, {RESP_OKAY, 32'h1});
        rd(8'h30, {RESP_SLVERR, 32'h0});
        wr(8'h30, 32'h0);
        wr(OFS_GEN_CTRL, 32'h80);
        rd(OFS_GEN_CTRL, {RESP_OKAY, 32'h80});
        cmp(usb_clk_en, 1);
        wr(OFS_DEV_CTRL, 32'h0);
        cmp(pad_idle, 0);
        wr(OFS_DEV_CTRL, 32'h1);
        cmp(pad_idle, 1);
        wr(OFS_DEV_CTRL, 32'h0);
        cmp(pad_idle, 0);
        wr(OFS_LINE, 32'ha0);
        cmp({dp_oe, dm_oe, dp_out, dm_out}, 4'he);
        rd(OFS_LINE, {RESP_OKAY, 32'ha2});
        wr(OFS_LINE, 32'h0);
        wr(OFS_DEV_INT_EN, 32'h10);
        host_u.drive(1'b1, 1'b0, 1'b1, 1'b0, 6);
        cmp(pad_idle, 1);
        host_u.drive(1'b0, 1'b1, 1'b0, 1'b0, 6);
        host_u.drive(1'b1, 1'b0, 1'b0, 1'b0, 6);
        cmp({pad_idle, irq_general, irq_endpoint}, 3'h2);
        wr(OFS_DEV_INT, 32'h0);
        cmp(irq_general, 0);
        wr(OFS_EP_SEL, 32'h0);
        wr(OFS_EP_CFG, 32'h3);
        rd(OFS_EP_CFG, {RESP_OKAY, 32'hb});
        wr(OFS_EP_SEL, 32'h1);
        wr(OFS_EP_CFG, 32'h3);
        rd(OFS_EP_BASE, {RESP_OKAY, 32'h8});
        wr(OFS_EP_SEL, 32'h0);
        wr(OFS_EP_CFG, 32'h13);
        wr(OFS_EP_SEL, 32'h2);
        rd(OFS_EP_BASE, {RESP_OKAY, 32'h10});
        wr(OFS_EP_SEL, 32'h1);
        rd(OFS_EP_BASE, {RESP_OKAY, 32'h10});
        wr(OFS_EP_SEL, 32'h0);
        wr(OFS_EP_INT_EN, 32'h1 << s);
        pulse();
        cmp({irq_endpoint, irq_general}, 2'h2);
        rd(OFS_EVENTS, {RESP_OKAY, 32'h1});
        wr(OFS_EP_INT, 32'h0);
        cmp(irq_endpoint, 0);
        wr(OFS_GEN_CTRL, 32'ha0);
        cmp(usb_clk_en, 0);
        pulse();
        cmp(irq_endpoint, 0);
        wr(OFS_DEV_CTRL, 32'h1);
        rd(OFS_DEV_CTRL, {RESP_OKAY, 32'h1});
        rd(OFS_GEN_CTRL, {RESP_OKAY, 32'ha0});
        wr(OFS_GEN_CTRL, 32'h80);
        cmp(irq_endpoint, 0);
        host_u.drive(1'b0, 1'b0, 1'b0, 1'b0, 8);
        host_u.drive(1'b1, 1'b0, 1'b0, 1'b1, 4);
        host_u.drive(1'b1, 1'b0, 1'b0, 1'b0, 4);
        rd(OFS_GEN_CTRL, {RESP_OKAY, 32'h80});
        rd(OFS_EP_CFG, {RESP_OKAY, 32'h0});
        rd(OFS_DEV_INT, {RESP_OKAY, 32'h18});
        sys_reset_req <= 1'b1;
        @(posedge aclk);
        sys_reset_req <= 1'b0;
        rd(OFS_GEN_CTRL, {RESP_OKAY, 32'h20});
        cmp(ctrl_reset, 1);
        repeat (2) @(posedge aclk);
        finish_test();
    end
endmodule : usb_device_general_control_bench
